// ---- rtl/fps_pin_sync.sv ----
`timescale 1ns/1ps
module fps_pin_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Two stages, third for edge finding
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule

// ---- rtl/fps_pkg.sv ----
package fps_pkg;

  // Serial opcodes
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_SMALL = 8'h20;
  localparam logic [7:0] OP_ERASE_LARGE = 8'h52;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9B;

  // Status byte bit positions
  localparam int unsigned SB_LOCK = 7;
  localparam int unsigned SB_FAIL = 5;
  localparam int unsigned SB_PIN = 4;
  localparam int unsigned SB_PROTECT = 2;
  localparam int unsigned SB_WEL = 1;
  localparam int unsigned SB_BUSY = 0;

  // Values after reset
  localparam logic RST_LOCK = 1'h0;
  localparam logic RST_PROTECT = 1'h0;
  localparam logic RST_FAIL = 1'h0;
  localparam logic RST_WEL = 1'h0;

  // Bit counting within a byte
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Pin synchroniser width: sclk, cs_n, si, wp_n
  localparam int unsigned PIN_W = 4;
  localparam int unsigned PIN_SCLK = 3;
  localparam int unsigned PIN_CS = 2;
  localparam int unsigned PIN_SI = 1;
  localparam int unsigned PIN_WP = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_WDATA = 3'h3,
    ST_RSTAT = 3'h2,
    ST_SKIP = 3'h6
  } fps_state_e;

  // Report from the array engine, same clock
  typedef struct packed {
    logic busy;
    logic done;
    logic fail;
    logic aborted;
  } fps_eng_rpt_s;

  // Request to the array engine
  typedef struct packed {
    logic start;
    logic [7:0] opcode;
  } fps_eng_req_s;

endpackage

// ---- rtl/fps_status_core.sv ----
`timescale 1ns/1ps
module fps_status_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire fps_pkg::fps_eng_rpt_s eng_rpt,
  input wire logic hold_abort,
  output logic so,
  output logic so_oe,
  output fps_pkg::fps_eng_req_s eng_req,
  output logic array_protect,
  output logic [7:0] status_byte
);
  // Decodes of command classes
  function automatic logic is_array_op(input logic [7:0] op);
    return op == fps_pkg::OP_PAGE_PROGRAM || op == fps_pkg::OP_ERASE_SMALL
      || op == fps_pkg::OP_ERASE_LARGE || op == fps_pkg::OP_ERASE_CHIP_A
      || op == fps_pkg::OP_ERASE_CHIP_B;
  endfunction

  function automatic logic is_engine_op(input logic [7:0] op);
    return is_array_op(op) || op == fps_pkg::OP_OTP_PROGRAM;
  endfunction

  logic [fps_pkg::PIN_W-1:0] pin_lvl;
  logic [fps_pkg::PIN_W-1:0] pin_rise;
  logic [fps_pkg::PIN_W-1:0] pin_fall;

  fps_pin_sync #(.W(fps_pkg::PIN_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({sclk, cs_n, si, wp_n}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  fps_pkg::fps_state_e state_q;
  fps_pkg::fps_state_e state_d;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] wbyte_q;
  logic wbyte_ok_q;
  logic lock_q;
  logic protect_q;
  logic fail_q;
  logic wel_q;
  logic wp_n_q;
  logic [2:0] tx_idx_q;
  logic [7:0] snap_q;
  logic so_q;
  logic so_oe_q;
  fps_pkg::fps_eng_req_s req_q;
  logic [7:0] status_q;

  // Pin events in the block's clock
  wire sclk_rise = pin_rise[fps_pkg::PIN_SCLK];
  wire sclk_fall = pin_fall[fps_pkg::PIN_SCLK];
  wire sel = ~pin_lvl[fps_pkg::PIN_CS];
  wire frame_start = pin_fall[fps_pkg::PIN_CS];
  wire frame_end = pin_rise[fps_pkg::PIN_CS];
  wire si_lvl = pin_lvl[fps_pkg::PIN_SI];
  wire wp_on = ~pin_lvl[fps_pkg::PIN_WP];

  // Serial byte assembly
  wire bit_take = sel && sclk_rise && state_q != fps_pkg::ST_IDLE;
  wire [7:0] shift_nx = {shift_q[6:0], si_lvl};
  wire byte_done = bit_take && bit_cnt_q == fps_pkg::BIT_LAST;
  wire aligned = bit_cnt_q == fps_pkg::BIT_FIRST;

  // Frame end decodes; an opcode frame still open never qualifies
  wire full_op = state_q != fps_pkg::ST_OPCODE
    && state_q != fps_pkg::ST_IDLE;
  wire end_op = frame_end && full_op;
  wire do_wren = end_op && opcode_q == fps_pkg::OP_WRITE_ENABLE;
  wire do_wrdi = end_op && opcode_q == fps_pkg::OP_WRITE_DISABLE;
  wire do_wrsr = end_op && opcode_q == fps_pkg::OP_WRITE_STATUS;
  wire do_eng = end_op && is_engine_op(opcode_q);

  // Status write checks
  wire new_lock = wbyte_q[fps_pkg::SB_LOCK];
  wire new_prot = wbyte_q[fps_pkg::SB_PROTECT];
  wire prot_frozen = lock_q && wp_on;
  wire lock_refused = wp_on && lock_q && !new_lock;
  wire wrsr_apply = do_wrsr && wel_q && wbyte_ok_q && aligned
    && !lock_refused;

  // Array program/erase gating
  wire eng_blocked = !wel_q || !aligned
    || (is_array_op(opcode_q) && protect_q);
  wire eng_go = do_eng && !eng_blocked;

  // Latch clear sources
  wire wel_clr = do_wrdi || do_wrsr
    || (do_eng && eng_blocked)
    || eng_rpt.done || hold_abort;

  // Live status byte
  wire [7:0] status_now = {lock_q, 1'b0, fail_q, wp_n_q, 1'b0,
    protect_q, wel_q, eng_rpt.busy};

  // Status shift-out selection
  wire tx_fresh = tx_idx_q == fps_pkg::BIT_LAST;
  wire [7:0] tx_byte = tx_fresh ? status_now : snap_q;
  wire tx_bit = tx_byte[tx_idx_q];
  wire tx_step = sel && sclk_fall && state_q == fps_pkg::ST_RSTAT;

  // Next state of the frame decoder
  always_comb begin
    state_d = state_q;
    case (state_q)
      fps_pkg::ST_IDLE: begin
        if (frame_start) begin
          state_d = fps_pkg::ST_OPCODE;
        end
      end
      fps_pkg::ST_OPCODE: begin
        if (!sel) begin
          state_d = fps_pkg::ST_IDLE;
        end else if (byte_done) begin
          if (shift_nx == fps_pkg::OP_READ_STATUS) begin
            state_d = fps_pkg::ST_RSTAT;
          end else if (shift_nx == fps_pkg::OP_WRITE_STATUS) begin
            state_d = fps_pkg::ST_WDATA;
          end else begin
            state_d = fps_pkg::ST_SKIP;
          end
        end
      end
      fps_pkg::ST_WDATA, fps_pkg::ST_RSTAT, fps_pkg::ST_SKIP: begin
        if (!sel) begin
          state_d = fps_pkg::ST_IDLE;
        end
      end
      default: state_d = fps_pkg::ST_IDLE;
    endcase
  end

  // Frame state and bit count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= fps_pkg::ST_IDLE;
      bit_cnt_q <= fps_pkg::BIT_FIRST;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (frame_start) begin
        bit_cnt_q <= fps_pkg::BIT_FIRST;
      end else if (bit_take) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q <= shift_nx;
      end
    end
  end

  // Opcode and first data byte capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      opcode_q <= 8'h00;
      wbyte_q <= 8'h00;
      wbyte_ok_q <= 1'b0;
    end else begin
      if (frame_start) begin
        wbyte_ok_q <= 1'b0;
      end else if (byte_done && state_q == fps_pkg::ST_OPCODE) begin
        opcode_q <= shift_nx;
      end else if (byte_done && state_q == fps_pkg::ST_WDATA
          && !wbyte_ok_q) begin
        wbyte_q <= shift_nx;
        wbyte_ok_q <= 1'b1;
      end
    end
  end

  // Lock and protect bits, changed only by status write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_q <= fps_pkg::RST_LOCK;
      protect_q <= fps_pkg::RST_PROTECT;
    end else if (wrsr_apply) begin
      lock_q <= new_lock;
      if (!prot_frozen) begin
        protect_q <= new_prot;
      end
    end
  end

  // Fail flag follows each finished operation that was not aborted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fail_q <= fps_pkg::RST_FAIL;
    end else if (eng_rpt.done && !eng_rpt.aborted) begin
      fail_q <= eng_rpt.fail;
    end
  end

  // Write enable latch; host enable wins a same-cycle clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wel_q <= fps_pkg::RST_WEL;
    end else if (do_wren) begin
      wel_q <= 1'b1;
    end else if (wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  // Engine request pulse and pin mirror
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_q <= '0;
      wp_n_q <= 1'b1;
    end else begin
      req_q.start <= eng_go;
      req_q.opcode <= eng_go ? opcode_q : req_q.opcode;
      wp_n_q <= ~wp_on;
    end
  end

  // Status stream out, refreshed at each byte start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_idx_q <= fps_pkg::BIT_LAST;
      snap_q <= 8'h00;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!sel || frame_start) begin
      tx_idx_q <= fps_pkg::BIT_LAST;
      so_oe_q <= 1'b0;
    end else if (tx_step) begin
      so_q <= tx_bit;
      so_oe_q <= 1'b1;
      tx_idx_q <= tx_idx_q - 3'h1;
      if (tx_fresh) begin
        snap_q <= status_now;
      end
    end
  end

  // Registered copies for the core
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_now;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign eng_req = req_q;
  assign array_protect = protect_q;
  assign status_byte = status_q;
endmodule

// ---- tb/fps_host_model.sv ----
`timescale 1ns/1ps
module fps_host_model (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Mode 0 shift, MSB first, so taken before each rise
  task bits(input logic [15:0] w, input int n, output logic [15:0] q);
    for (int i = 0; i < n; i++) begin
      si <= w[15 - i];
      repeat (5) @(posedge clock);
      q = {q[14:0], so};
      sclk <= 1'b1;
      repeat (5) @(posedge clock);
      sclk <= 1'b0;
    end
  endtask
  // One framed transfer of n bits
  task frame(input logic [15:0] w, input int n, output logic [7:0] q);
    logic [15:0] r;
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (5) @(posedge clock);
    bits(w, n, r);
    repeat (5) @(posedge clock);
    cs_n <= 1'b1;
    si <= ~si;
    q = r[7:0];
    repeat (12) @(posedge clock);
  endtask
  // Stream status until busy drops, bounded
  task poll(output logic ok);
    logic [15:0] r;
    ok = 1'b0;
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (5) @(posedge clock);
    bits(16'h0500, 8, r);
    for (int k = 0; k < 40 && !ok; k++) begin
      bits(16'h0000, 8, r);
      ok = !r[0];
    end
    repeat (5) @(posedge clock);
    cs_n <= 1'b1;
    repeat (12) @(posedge clock);
  endtask
endmodule

// ---- tb/fps_status_core_properties.sv ----
`timescale 1ns/1ps
module fps_status_core_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire fps_pkg::fps_eng_rpt_s eng_rpt,
  input wire logic hold_abort,
  input wire logic so,
  input wire logic so_oe,
  input wire fps_pkg::fps_eng_req_s eng_req,
  input wire logic array_protect,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Engine end that is not an abort
  sequence op_end;
    eng_rpt.done && !eng_rpt.aborted;
  endsequence
  // Status bits against their causes
  a_reset_clear: assert property (
    $rose(rst_n) |-> status_byte == 8'h00) else $error("reset");
  a_busy_live: assert property (
    $past(rst_n) |-> status_byte[0] == $past(eng_rpt.busy))
    else $error("busy");
  a_fail_load: assert property (
    op_end |-> ##3 status_byte[5] == $past(eng_rpt.fail, 3))
    else $error("fail");
  a_abort_keep: assert property (
    eng_rpt.done && eng_rpt.aborted |-> ##3 $stable(status_byte[5]))
    else $error("abort");
  a_wel_clear: assert property (
    eng_rpt.done || hold_abort |-> ##3 !status_byte[1])
    else $error("wel");
  a_start_gate: assert property (
    eng_req.start |-> status_byte[1] && (!array_protect
    || eng_req.opcode == fps_pkg::OP_OTP_PROGRAM)) else $error("start");
  a_lock_hold: assert property (
    status_byte[7] && !status_byte[4] |=> status_byte[7])
    else $error("lock");
  a_protect_hold: assert property (
    status_byte[7] && !status_byte[4] |=> $stable(array_protect))
    else $error("protect");
  // Chip select held high long enough to pass the synchroniser
  sequence cs_idle;
    cs_n [*4];
  endsequence
  // Data line driven only inside a status read
  a_oe_release: assert property (
    cs_idle |-> !so_oe) else $error("oe idle");
  a_oe_drive: assert property (
    $changed(so) |-> so_oe) else $error("oe drive");
endmodule
bind fps_status_core fps_status_core_properties u_props (.clock(clock),
  .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
  .eng_rpt(eng_rpt), .hold_abort(hold_abort), .so(so), .so_oe(so_oe),
  .eng_req(eng_req), .array_protect(array_protect),
  .status_byte(status_byte));

// ---- tb/fps_status_core_tb.sv ----
`timescale 1ns/1ps
module fps_status_core_tb;
  logic clock = 0, rst_n = 0, wp_n = 1, hold_abort = 0, so, so_oe;
  logic sclk, cs_n, si, ok, array_protect;
  logic [7:0] status_byte, q;
  fps_pkg::fps_eng_rpt_s eng_rpt = '0;
  fps_pkg::fps_eng_req_s eng_req;
  int fail_count = 0, tests_run = 0, starts = 0;
  // Undriven data line shows the inverse of the last bit
  wire so_line = so_oe ? so : ~so;
  fps_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so(so_line));
  fps_status_core uut (.clock(clock), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .eng_rpt(eng_rpt),
    .hold_abort(hold_abort), .so(so), .so_oe(so_oe), .eng_req(eng_req),
    .array_protect(array_protect), .status_byte(status_byte));
  initial begin
    forever #4 clock = ~clock;
  end
  // Count engine start pulses
  always @(posedge clock) begin
    if (eng_req.start === 1'b1) starts++;
  end
  task chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task we;
    host.frame(16'h0600, 8, q);
  endtask
  task done(input logic f, a);
    eng_rpt <= '{1'b0, 1'b1, f, a};
    wt(1);
    eng_rpt <= '0;
    wt(5);
  endtask
  task t_reset;
    chk(status_byte, 8'h10);
    host.frame(16'h0500, 16, q);
    chk(q, 8'h10);
  endtask
  task t_protect;
    we();
    chk(status_byte, 8'h12);
    host.frame(16'h01FF, 16, q);
    chk(status_byte, 8'h94);
    chk(8'(array_protect), 8'h01);
    wp_n <= 1'b0;
    wt(8);
    chk(status_byte, 8'h84);
    we();
    host.frame(16'h0180, 16, q);
    chk(status_byte, 8'h84);
    we();
    host.frame(16'h0100, 16, q);
    chk(status_byte, 8'h84);
    we();
    host.frame(16'h0200, 16, q);
    chk(status_byte, 8'h84);
    chk(8'(starts), 8'h00);
    wp_n <= 1'b1;
    wt(8);
    host.frame(16'h0100, 16, q);
    chk(status_byte, 8'h94);
    we();
    host.frame(16'h0100, 16, q);
    chk(status_byte, 8'h10);
  endtask
  task t_engine;
    we();
    host.frame(16'h0200, 16, q);
    chk(8'(starts), 8'h01);
    chk(eng_req.opcode, fps_pkg::OP_PAGE_PROGRAM);
    eng_rpt.busy <= 1'b1;
    fork
      begin
        wt(300);
        eng_rpt.busy <= 1'b0;
      end
      host.poll(ok);
    join
    chk(8'(ok), 8'h01);
    if (ok !== 1'b1) results();
    done(1'b1, 1'b0);
    chk(status_byte, 8'h30);
    we();
    host.frame(16'h2000, 8, q);
    done(1'b0, 1'b0);
    chk(status_byte, 8'h10);
    we();
    host.frame(16'h0200, 16, q);
    done(1'b1, 1'b1);
    chk(status_byte, 8'h10);
  endtask
  task t_abort;
    we();
    host.frame(16'h0200, 4, q);
    chk(status_byte, 8'h12);
    hold_abort <= 1'b1;
    wt(1);
    hold_abort <= 1'b0;
    wt(5);
    chk(status_byte, 8'h10);
    we();
    host.frame(16'h0200, 12, q);
    chk(status_byte, 8'h10);
    chk(8'(starts), 8'h03);
  endtask
  task t_codes;
    we();
    host.frame(16'h0400, 8, q);
    chk(status_byte, 8'h10);
    we();
    host.frame(16'h0180, 12, q);
    chk(status_byte, 8'h10);
    we();
    host.frame(16'h0104, 16, q);
    chk(status_byte, 8'h14);
    we();
    host.frame(16'hC700, 8, q);
    chk(status_byte, 8'h14);
    chk(8'(starts), 8'h03);
    we();
    host.frame(16'h9B00, 16, q);
    chk(8'(starts), 8'h04);
    chk(eng_req.opcode, fps_pkg::OP_OTP_PROGRAM);
    done(1'b0, 1'b0);
    chk(status_byte, 8'h14);
    we();
    host.frame(16'h0100, 16, q);
    chk(status_byte, 8'h10);
    we();
    host.frame(16'h5200, 8, q);
    done(1'b0, 1'b0);
    we();
    host.frame(16'h6000, 8, q);
    done(1'b0, 1'b0);
    chk(8'(starts), 8'h06);
    chk(status_byte, 8'h10);
  endtask
  task t_rerun;
    we();
    host.frame(16'h0184, 16, q);
    chk(status_byte, 8'h94);
    we();
    chk(status_byte, 8'h96);
    rst_n <= 1'b0;
    wt(4);
    rst_n <= 1'b1;
    wt(8);
    chk(status_byte, 8'h10);
    chk(8'(array_protect), 8'h00);
    host.frame(16'h0500, 16, q);
    chk(q, 8'h10);
  endtask
  initial begin
    wt(4);
    rst_n <= 1'b1;
    wt(8);
    t_reset();
    t_protect();
    t_engine();
    t_abort();
    t_codes();
    t_rerun();
    results();
  end
endmodule
